/* File: inc/stm_defines.svh */
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define STM_ADDR_CTRL0 4'h0
`define STM_ADDR_CTRL1 4'h1
`define STM_ADDR_COUNT 4'h2
`define STM_ADDR_CMPA 4'h3
`define STM_ADDR_CMPP 4'h4
`define STM_ADDR_FLAGS 4'h5

// ****************************************************************
// field positions
// ****************************************************************
`define STM_C0_ON_BIT 3
`define STM_C0_FALL_BIT 0
`define STM_FL_A_BIT 0
`define STM_FL_P_BIT 1

// ****************************************************************
// reset values
// ****************************************************************
`define STM_CTRL1_RST 8'h00
`define STM_CMPA_RST 16'h0000
`define STM_CMPP_RST 8'h00
`define STM_COUNT_RST 16'h0000

// ****************************************************************
// timing counts
// ****************************************************************
`define STM_P_FULL_PERIOD 17'h10000
`define STM_P_STEP_LOW 8'h00

`endif

/* File: inc/stm_pkg.sv */
`default_nettype none
package stm_pkg;

  // operating mode field
  typedef enum logic [1:0] {
    STM_MODE_CMP = 2'b00,
    STM_MODE_UNDEF = 2'b01,
    STM_MODE_PWM = 2'b10,
    STM_MODE_TC = 2'b11
  } stm_mode_t;

  // pin action field
  typedef enum logic [1:0] {
    STM_ACT_00 = 2'b00,
    STM_ACT_01 = 2'b01,
    STM_ACT_10 = 2'b10,
    STM_ACT_11 = 2'b11
  } stm_act_t;

endpackage : stm_pkg
`default_nettype wire

/* File: hdl/stm_core.sv */
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "stm_defines.svh"

module stm_core
  import stm_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // timer clock enable and external clock pin
  input wire logic tmr_tick_i,
  input wire logic ext_clock_pin_i,
  // output pin and status
  output logic tmr_out_o,
  output logic tmr_out_oe_o,
  output logic match_a_flag_o,
  output logic match_p_flag_o,
  output logic counter_on_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic counter_on_ff;
  logic ext_fall_ff;
  logic [7:0] ctrl1_ff;
  logic [15:0] compare_a_value_ff;
  logic [7:0] compare_p_value_ff;
  logic [15:0] cnt_ff;
  logic match_a_flag_ff;
  logic match_p_flag_ff;
  logic cmp_pin_ff;
  logic out_ff;
  logic oe_ff;
  logic [15:0] rdata_ff;
  logic ext_s1_ff;
  logic ext_s2_ff;
  logic ext_s3_ff;

  // ****************************************************************
  // decode of control fields
  // ****************************************************************
  stm_mode_t mode;
  stm_act_t pin_action_sel;
  wire output_init_level = ctrl1_ff[3];
  wire output_invert = ctrl1_ff[2];
  wire duty_period_swap = ctrl1_ff[1];
  wire clear_select = ctrl1_ff[0];
  assign mode = stm_mode_t'(ctrl1_ff[7:6]);
  assign pin_action_sel = stm_act_t'(ctrl1_ff[5:4]);

  // undefined mode is handled like timer/counter: counts, no drive
  wire is_cmp_like = (mode != STM_MODE_PWM);
  wire is_sp = (mode == STM_MODE_PWM) && (pin_action_sel == STM_ACT_11);
  wire is_pwm = (mode == STM_MODE_PWM) && !is_sp;
  wire drive_pin = (mode == STM_MODE_CMP) || (mode == STM_MODE_PWM);

  // ****************************************************************
  // register port decode
  // ****************************************************************
  wire wr_ctrl0 = reg_wr_i && (reg_addr_i == `STM_ADDR_CTRL0);
  wire wr_ctrl1 = reg_wr_i && (reg_addr_i == `STM_ADDR_CTRL1);
  wire wr_cmpa = reg_wr_i && (reg_addr_i == `STM_ADDR_CMPA);
  wire wr_cmpp = reg_wr_i && (reg_addr_i == `STM_ADDR_CMPP);
  wire wr_flags = reg_wr_i && (reg_addr_i == `STM_ADDR_FLAGS);
  wire clr_a = wr_flags && reg_wdata_i[`STM_FL_A_BIT];
  wire clr_p = wr_flags && reg_wdata_i[`STM_FL_P_BIT];

  // ****************************************************************
  // external clock pin: two-stage sync then edge detect
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end else begin
      ext_s1_ff <= ext_clock_pin_i;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  // edge picked by ctrl0 so either polarity of trigger can be used
  wire ext_rise = ext_s2_ff && !ext_s3_ff;
  wire ext_fallen = !ext_s2_ff && ext_s3_ff;
  wire ext_edge = ext_fall_ff ? ext_fallen : ext_rise;

  // ****************************************************************
  // comparators
  // ****************************************************************
  wire cnt_run = tmr_tick_i && counter_on_ff;
  wire [16:0] cnt_sum = {1'b0, cnt_ff} + 17'h00001;
  wire [15:0] cnt_inc = cnt_sum[15:0];
  wire a_nonzero = (compare_a_value_ff != 16'h0000);
  // zero compare value never matches, counter simply wraps at FFFF
  wire hit_a = cnt_run && a_nonzero && (cnt_inc == compare_a_value_ff);
  // P compares the upper byte, with the lower byte zero, so zero matches at the 65536 wrap
  wire hit_p = cnt_run && (cnt_inc[15:8] == compare_p_value_ff) &&
               (cnt_inc[7:0] == `STM_P_STEP_LOW);

  // clear source: clear_select in compare modes, swap bit in PWM
  wire clr_by_a = is_cmp_like ? clear_select :
                  (is_pwm && duty_period_swap);
  wire clr_by_p = is_cmp_like ? !clear_select :
                  (is_pwm && !duty_period_swap);
  // single pulse never clears on a match
  wire cnt_clear = (clr_by_a && hit_a) || (clr_by_p && hit_p);

  // flag sources
  wire set_a = hit_a;
  wire set_p = hit_p && (is_pwm ||
               (is_cmp_like && !clear_select));

  // ****************************************************************
  // counter_on next value
  // ****************************************************************
  // a match ends the pulse, but software or the pin may restart it
  logic nxt_counter_on;
  always_comb begin
    nxt_counter_on = counter_on_ff;
    if (is_sp && hit_a) begin
      nxt_counter_on = 1'b0;
    end
    if (wr_ctrl0) begin
      nxt_counter_on = reg_wdata_i[`STM_C0_ON_BIT];
    end
    if (is_sp && ext_edge) begin
      nxt_counter_on = 1'b1;
    end
  end

  wire on_set = !counter_on_ff && nxt_counter_on;

  // control registers
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      counter_on_ff <= 1'b0;
      ext_fall_ff <= 1'b0;
      ctrl1_ff <= `STM_CTRL1_RST;
      compare_a_value_ff <= `STM_CMPA_RST;
      compare_p_value_ff <= `STM_CMPP_RST;
    end else begin
      counter_on_ff <= nxt_counter_on;
      if (wr_ctrl0) begin
        ext_fall_ff <= reg_wdata_i[`STM_C0_FALL_BIT];
      end
      if (wr_ctrl1) begin
        ctrl1_ff <= reg_wdata_i[7:0];
      end
      if (wr_cmpa) begin
        compare_a_value_ff <= reg_wdata_i;
      end
      if (wr_cmpp) begin
        compare_p_value_ff <= reg_wdata_i[7:0];
      end
    end
  end

  // ****************************************************************
  // counter
  // ****************************************************************
  logic [15:0] nxt_cnt;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (on_set) begin
      nxt_cnt = `STM_COUNT_RST;
    end else if (cnt_run) begin
      nxt_cnt = cnt_clear ? `STM_COUNT_RST : cnt_inc;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= `STM_COUNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ****************************************************************
  // match flags: a set in the clearing cycle wins
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      match_a_flag_ff <= 1'b0;
      match_p_flag_ff <= 1'b0;
    end else begin
      match_a_flag_ff <= (match_a_flag_ff && !clr_a) || set_a;
      match_p_flag_ff <= (match_p_flag_ff && !clr_p) || set_p;
    end
  end

  // ****************************************************************
  // compare-match pin state
  // ****************************************************************
  logic nxt_cmp_pin;
  always_comb begin
    nxt_cmp_pin = cmp_pin_ff;
    if (on_set) begin
      nxt_cmp_pin = output_init_level;
    end else if (is_cmp_like && hit_a) begin
      case (pin_action_sel)
        STM_ACT_01: nxt_cmp_pin = 1'b0;
        STM_ACT_10: nxt_cmp_pin = 1'b1;
        STM_ACT_11: nxt_cmp_pin = !cmp_pin_ff;
        default: nxt_cmp_pin = cmp_pin_ff;
      endcase
    end
  end

  // ****************************************************************
  // PWM and single pulse active phase
  // ****************************************************************
  // P duty is 17 bits wide so a zero value reaches the full 65536
  wire [16:0] duty_p = (compare_p_value_ff == 8'h00) ?
                       `STM_P_FULL_PERIOD :
                       {1'b0, compare_p_value_ff, `STM_P_STEP_LOW};
  // duty at or past period is never crossed, so stays active
  wire pwm_wave = duty_period_swap ? ({1'b0, cnt_ff} < duty_p) :
                  (cnt_ff < compare_a_value_ff);
  // forced levels only mask the pin; the counter keeps running
  logic pwm_active;
  always_comb begin
    case (pin_action_sel)
      STM_ACT_00: pwm_active = 1'b0;
      STM_ACT_01: pwm_active = 1'b1;
      STM_ACT_10: pwm_active = pwm_wave;
      STM_ACT_11: pwm_active = counter_on_ff;
      default: pwm_active = 1'b0;
    endcase
  end

  // init level is the active level; invert applied last
  wire pwm_level = pwm_active ? output_init_level :
                   !output_init_level;
  wire pin_state = (mode == STM_MODE_PWM) ? pwm_level : cmp_pin_ff;
  wire nxt_out = pin_state ^ output_invert;

  // pin output registers, one cycle behind the internal state
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_pin_ff <= 1'b0;
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      cmp_pin_ff <= nxt_cmp_pin;
      out_ff <= nxt_out;
      oe_ff <= drive_pin;
    end
  end

  // ****************************************************************
  // read data, valid the cycle after the strobe
  // ****************************************************************
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      `STM_ADDR_CTRL0: rd_mux = {12'h000, counter_on_ff, 2'b00, ext_fall_ff};
      `STM_ADDR_CTRL1: rd_mux = {8'h00, ctrl1_ff};
      `STM_ADDR_COUNT: rd_mux = cnt_ff;
      `STM_ADDR_CMPA: rd_mux = compare_a_value_ff;
      `STM_ADDR_CMPP: rd_mux = {8'h00, compare_p_value_ff};
      `STM_ADDR_FLAGS: rd_mux = {14'h0000, match_p_flag_ff, match_a_flag_ff};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= reg_rd_i ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign tmr_out_o = out_ff;
  assign tmr_out_oe_o = oe_ff;
  assign match_a_flag_o = match_a_flag_ff;
  assign match_p_flag_o = match_p_flag_ff;
  assign counter_on_o = counter_on_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_cmp_mode_drive: assert property (
    (mode == STM_MODE_CMP) |=> tmr_out_oe_o)
    else $error("compare mode does not drive pin");

  a_p_match_clear: assert property (
    (mode == STM_MODE_CMP) && !clear_select && hit_p && !on_set
    |=> (cnt_ff == 16'h0000) && match_p_flag_o)
    else $error("P match did not clear counter");

  a_no_p_flag: assert property (
    $rose(match_p_flag_ff) |-> $past(!clear_select || is_pwm))
    else $error("P flag set with A clear select");

  a_zero_a_flag: assert property (
    $rose(match_a_flag_ff) |-> $past(compare_a_value_ff != 16'h0000))
    else $error("A flag raised with zero compare");

  a_p_keeps_pin: assert property (
    is_cmp_like && hit_p && !hit_a && !on_set |=> $stable(cmp_pin_ff))
    else $error("P match changed pin");

  a_toggle_pin: assert property (
    is_cmp_like && hit_a && (pin_action_sel == STM_ACT_11)
    |=> cmp_pin_ff == !$past(cmp_pin_ff))
    else $error("toggle action missed");

  a_init_level: assert property (
    on_set |=> (cmp_pin_ff == $past(output_init_level)))
    else $error("pin not loaded at start");

  a_tc_no_drive: assert property (
    (mode == STM_MODE_TC) |=> !tmr_out_oe_o)
    else $error("timer mode drives pin");

  a_force_active: assert property (
    is_pwm && (pin_action_sel == STM_ACT_01) && !wr_ctrl1
    |=> tmr_out_o == ($past(output_init_level) ^ $past(output_invert)))
    else $error("forced active level wrong");

  a_sp_stop: assert property (
    is_sp && hit_a && !wr_ctrl0 && !wr_ctrl1 && !ext_edge
    |=> !counter_on_o && match_a_flag_o ##1
    tmr_out_o == !($past(output_init_level) ^ $past(output_invert)))
    else $error("single pulse not ended by A");

  a_ext_start: assert property (
    is_sp && ext_edge && !counter_on_ff |=> counter_on_o && cnt_ff == 16'h0000)
    else $error("pin edge did not start pulse");

  a_cnt_hold: assert property (
    !counter_on_ff && !on_set |=> $stable(cnt_ff))
    else $error("counter moved while off");

endmodule : stm_core
`default_nettype wire

/* File: tb/stm_load.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// external load on the timer pin, plus external trigger source
// ****************************************************************
module stm_load (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // timer pin as seen by the load
  input wire logic pin_i,
  input wire logic pin_oe_i,
  // bench controls
  input wire logic clr_i,
  input wire logic fire_i,
  // measurements and trigger line
  output logic [15:0] high_cnt_o,
  output logic ext_pin_o
);
  logic lvl;
  // an undriven pin sits at the pull-down level, never the last value
  assign lvl = pin_oe_i & pin_i;
  // active-cycle counter; trigger line only moves on bench request
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_cnt_o <= 16'h0000;
      ext_pin_o <= 1'b0;
    end else begin
      ext_pin_o <= fire_i;
      if (clr_i) begin
        high_cnt_o <= 16'h0000;
      end else begin
        high_cnt_o <= high_cnt_o + {15'h0000, lvl};
      end
    end
  end
endmodule : stm_load

`default_nettype wire

/* File: tb/stm_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "stm_defines.svh"

module stm_core_tb
  import stm_pkg::*;
;
  logic sys_clk_i, arst_n_i, reg_wr_i, reg_rd_i, tmr_tick_i, clr, fire;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, high_cnt, v, w;
  logic tmr_out_o, tmr_out_oe_o, match_a_flag_o, match_p_flag_o;
  logic counter_on_o, ext_pin;
  logic [1:0] act;
  logic ini, pin_exp;
  int error_cnt, total_checks, cyc_cnt;
  logic [15:0] pc1 [0:6] = '{16'h00A9, 16'h00A0, 16'h00AC, 16'h00A8,
    16'h00AA, 16'h0088, 16'h0098};
  logic [15:0] pa [0:6] = '{16'h0040, 16'h0040, 16'h0040, 16'h012C,
    16'h0200, 16'h0040, 16'h0040};
  logic [15:0] ph [0:6] = '{16'h0100, 16'h0300, 16'h0300, 16'h0400,
    16'h0200, 16'h0000, 16'h0400};

  // ****************************************************************
  // design, load and clock
  // ****************************************************************
  stm_core u_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .tmr_tick_i(tmr_tick_i), .ext_clock_pin_i(ext_pin),
    .tmr_out_o(tmr_out_o), .tmr_out_oe_o(tmr_out_oe_o),
    .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o),
    .counter_on_o(counter_on_o));
  stm_load u_load (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .pin_i(tmr_out_o), .pin_oe_i(tmr_out_oe_o), .clr_i(clr),
    .fire_i(fire), .high_cnt_o(high_cnt), .ext_pin_o(ext_pin));
  always #5 sys_clk_i = ~sys_clk_i;
  // hang guard, well above the roughly 10k cycles the tests need
  always @(posedge sys_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  // ****************************************************************
  // bus, measurement and compare tasks
  // ****************************************************************
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd_reg
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wt
  task automatic run(input logic on);
    wr_reg(`STM_ADDR_CTRL0, {12'h000, on, 3'h0});
  endtask : run
  task automatic setup(input logic [7:0] c1, input logic [15:0] a,
                       input logic [7:0] p);
    run(1'b0);
    wr_reg(`STM_ADDR_FLAGS, 16'h0003);
    wr_reg(`STM_ADDR_CMPA, a);
    wr_reg(`STM_ADDR_CMPP, {8'h00, p});
    wr_reg(`STM_ADDR_CTRL1, {8'h00, c1});
  endtask : setup
  // whole periods in the window make the count phase-independent
  task automatic meas(input int n);
    @(posedge sys_clk_i);
    clr <= 1'b1;
    @(posedge sys_clk_i);
    clr <= 1'b0;
    wt(n);
  endtask : meas
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [15:0] flg();
    return {14'h0000, match_p_flag_o, match_a_flag_o};
  endfunction : flg
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    sys_clk_i = 1'b0;
    arst_n_i = 1'b0;
    {reg_wr_i, reg_rd_i, clr, fire} = 4'h0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    tmr_tick_i = 1'b1;
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    // reset values, unmapped index reads zero
    for (int i = 0; i < 7; i++) begin
      rd_reg((i == 6) ? 4'hF : 4'(i), v);
      chk(v, 16'h0000);
    end
    $display("test reset done");
    // every pin action code, both initial levels
    for (int k = 0; k < 8; k++) begin
      act = 2'(k >> 1);
      ini = k[0];
      setup({2'b00, act, ini, 3'h1}, 16'h0005, 8'h00);
      run(1'b1);
      wt(3);
      chk({15'h0000, tmr_out_o}, {15'h0000, ini});
      chk({15'h0000, tmr_out_oe_o}, 16'h0001);
      // one A match has reached the pin, so a toggle shows inverted
      wt(4);
      pin_exp = (act == 2'b01) ? 1'b0 : (act == 2'b10) ? 1'b1 :
                (act == 2'b11) ? !ini : ini;
      chk({15'h0000, tmr_out_o}, {15'h0000, pin_exp});
    end
    $display("test pin actions done");
    // clear on A with P below A: no P flag
    setup(8'h31, 16'h0180, 8'h01);
    run(1'b1);
    meas(768);
    chk(high_cnt, 16'h0180);
    chk(flg(), 16'h0001);
    // clear on P; A beyond the period never moves the pin
    for (int j = 0; j < 2; j++) begin
      setup(8'h38, j ? 16'h0200 : 16'h0040, 8'h01);
      run(1'b1);
      meas(512);
      chk(high_cnt, j ? 16'h0200 : 16'h0100);
      chk(flg(), j ? 16'h0002 : 16'h0003);
    end
    $display("test compare clear done");
    // timer/counter with A zero: runs past, no A flag, no drive
    setup({STM_MODE_TC, 6'h01}, 16'h0000, 8'h00);
    run(1'b1);
    wt(300);
    rd_reg(`STM_ADDR_COUNT, v);
    chk({15'h0000, v > 16'h0120}, 16'h0001);
    chk(flg(), 16'h0000);
    chk({15'h0000, tmr_out_oe_o}, 16'h0000);
    @(posedge sys_clk_i);
    tmr_tick_i <= 1'b0;
    rd_reg(`STM_ADDR_COUNT, v);
    wt(5);
    rd_reg(`STM_ADDR_COUNT, w);
    chk(w, v);
    @(posedge sys_clk_i);
    tmr_tick_i <= 1'b1;
    run(1'b0);
    rd_reg(`STM_ADDR_COUNT, v);
    wt(5);
    rd_reg(`STM_ADDR_COUNT, w);
    chk(w, v);
    $display("test timer counter done");
    // pwm table: period, duty, swap, polarity, forced levels
    for (int i = 0; i < 7; i++) begin
      setup(pc1[i][7:0], pa[i], 8'h01);
      run(1'b1);
      meas(1024);
      chk(high_cnt, ph[i]);
      chk(flg(), (i == 3) ? 16'h0002 : 16'h0003);
    end
    $display("test pwm done");
    // single pulse by software; swap set but unused, clear select left clear
    setup(8'hBA, 16'h0014, 8'h00);
    meas(0);
    run(1'b1);
    wt(40);
    chk(high_cnt, 16'h0014);
    chk({15'h0000, counter_on_o}, 16'h0000);
    chk(flg(), 16'h0001);
    rd_reg(`STM_ADDR_COUNT, v);
    chk(v, 16'h0014);
    // single pulse from the external pin
    meas(0);
    @(posedge sys_clk_i);
    fire <= 1'b1;
    wt(6);
    chk({15'h0000, counter_on_o}, 16'h0001);
    wt(34);
    chk(high_cnt, 16'h0014);
    // falling trigger edge, picked by ctrl0 bit 0
    wr_reg(`STM_ADDR_CTRL0, 16'h0001);
    meas(0);
    @(posedge sys_clk_i);
    fire <= 1'b0;
    wt(6);
    chk({15'h0000, counter_on_o}, 16'h0001);
    wt(34);
    chk(high_cnt, 16'h0014);
    // software clear cuts a long pulse short
    setup(8'hB8, 16'h00C8, 8'h00);
    run(1'b1);
    wt(10);
    run(1'b0);
    wt(4);
    chk({14'h0000, counter_on_o, tmr_out_o}, 16'h0000);
    $display("test single pulse done");
    conclude();
  end
endmodule : stm_core_tb

`default_nettype wire
